// ### rtl/mrp_pkg.sv
// shared constants and types for the mode register read and partial-array retention block
package mrp_pkg;
    // link widths
    localparam int CA_W = 10;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int BANKS = 8;
    localparam int SEGS = 8;

    // clock rate and timing figures
    localparam int CLK_MHZ = 250;
    localparam int TSI_MS = 32;
    localparam int TSI_CYC = TSI_MS * 1000 * CLK_MHZ;
    localparam int REFI_NS = 3900;
    localparam int REF_STEP_CYC = REFI_NS * CLK_MHZ / 1000;
    localparam int XSR_LINK_CYC = 8;
    localparam int RL_DEF = 3;
    localparam int TSI_W = 24;

    // mode register addresses served by a register read
    localparam logic [7:0] MA_TEMP = 8'h04;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    localparam logic [7:0] MA_CAL_A = 8'h20;
    localparam logic [7:0] MA_CAL_B = 8'h28;

    // calibration patterns, bit n is beat n
    localparam logic [3:0] CAL_A_PAT = 4'h5;
    localparam logic [3:0] CAL_B_PAT = 4'hc;

    // command codes on ca[3:0] at the rising edge
    localparam logic [3:0] CMD_MRR = 4'h8;
    localparam logic [2:0] CMD_REF = 3'h4;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // apb register offsets
    localparam logic [11:0] OFS_BANK_MASK = 12'h000;
    localparam logic [11:0] OFS_SEG_MASK = 12'h004;
    localparam logic [11:0] OFS_CONFIG = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_TEMP = 12'h010;

    // status bit positions
    localparam int ST_SR = 0;
    localparam int ST_XSR = 1;
    localparam int ST_MRR = 2;
    localparam int ST_ERR_NOREF = 3;
    localparam int ST_ERR_XSRCMD = 4;

    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] RL_RST = 4'h3;

    // whole state of the core
    typedef struct packed {
        logic ck_s1, ck_s2, ck_s3;
        logic cke_s1, cke_s2, cs_n_s1, cs_n_s2;
        logic [CA_W-1:0] ca_s1, ca_s2;
        logic [2:0] temp_s1, temp_s2;
        logic [7:0] bank_mask, seg_mask;
        logic [3:0] rl;
        logic [2:0] temp_status;
        logic [TSI_W-1:0] tsi_cnt;
        logic cke_prev, sr_active, ref_ok;
        logic [7:0] xsr_cnt;
        logic [3:0] pb_cnt;
        logic err_noref, err_xsrcmd;
        logic [9:0] ref_timer;
        logic [5:0] ref_ptr;
        logic ref_stb;
        logic [2:0] ref_bank, ref_seg;
        logic wait_fall, lat_run, burst_on;
        logic [5:0] addr_lo;
        logic [7:0] addr;
        logic [3:0] lat_cnt;
        logic [1:0] beat;
        logic [DQ_W-1:0] dq_o;
        logic dq_oe;
        logic [LANES-1:0] dqs_t, dqs_c;
        logic dqs_oe;
        logic pready, pslverr;
        logic [31:0] prdata;
    } mrp_state_type;
endpackage

// ### rtl/mrp_core.sv
// mode register read, partial-array retention self refresh and temperature status core
//
// Behaviour
// - eight-bit bank mask; masked banks get no self refresh.
// - unmasked banks are refreshed per the segment mask bits.
// - eight-bit segment mask applies across all banks; masked segments not refreshed.
// - mask bit one means blocked, zero means refreshed.
// - register read decoded with chip select low, CA2..0 low, CA3 high.
// - address is falling CA1..0 as upper bits, rising CA9..4 lower.
// - register value on low byte, first beat, after read latency.
// - four-beat uninterrupted burst, every strobe pair toggling throughout.
// - reserved or write-only addresses return defined filler with strobes toggling.
// - temperature status refreshed at most every 32 ms and on exit.
// - calibration address returns its fixed pattern on bit zero of each lane.
// - during calibration reads all lane bits copy lane bit zero.
// - pattern A is 1,0,1,0 over beats zero to three.
// - pattern B is 0,0,1,1 over beats zero to three.
`timescale 1ns/1ns
module mrp_core
    import mrp_pkg::*;
#(
    parameter int TSI_CYCLES = TSI_CYC,
    parameter int XSR_CYCLES = XSR_LINK_CYC
) (
    // system clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // memory link from the controller
    input wire logic CK,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic [CA_W-1:0] CA,
    // read data and strobes towards the controller
    output logic [DQ_W-1:0] DQ_O,
    output logic DQ_OE,
    output logic [LANES-1:0] DQS_T_O,
    output logic [LANES-1:0] DQS_C_O,
    output logic DQS_OE,
    // on-die temperature sensor code
    input wire logic [2:0] TEMP_CODE,
    // internal array refresh requests
    output logic ARRAY_REF_STB,
    output logic [2:0] ARRAY_REF_BANK,
    output logic [2:0] ARRAY_REF_SEG
);

    // parameter checks
    if (TSI_CYCLES < 2 || TSI_CYCLES >= (1 << TSI_W)) begin : g_chk_tsi
        $error("TSI_CYCLES out of range");
    end
    if (XSR_CYCLES < 1 || XSR_CYCLES > 255) begin : g_chk_xsr
        $error("XSR_CYCLES out of range");
    end

    mrp_state_type st_r;
    mrp_state_type st_nxt;
    logic ck_rise;
    logic ck_fall;
    logic cmd_valid;
    logic mrr_busy;
    logic apb_setup;
    logic apb_write;
    logic tsi_wrap;
    logic ref_step;

    // register value seen by a read of a mode register address
    function automatic logic [7:0] reg_value(input mrp_state_type s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == MA_TEMP) begin
            v = {5'h00, s.temp_status};
        end else if (a == MA_BANK_MASK) begin
            v = s.bank_mask;
        end else if (a == MA_SEG_MASK) begin
            v = s.seg_mask;
        end
        return v;
    endfunction

    // data word for one beat of a register read burst
    function automatic logic [DQ_W-1:0] beat_word(input mrp_state_type s, input logic [7:0] a,
                                                  input logic [1:0] b);
        logic [DQ_W-1:0] w;
        w = '0;
        if (a == MA_CAL_A) begin
            w = {DQ_W{CAL_A_PAT[b]}};
        end else if (a == MA_CAL_B) begin
            w = {DQ_W{CAL_B_PAT[b]}};
        end else if (b == 2'd0) begin
            w = {24'h000000, reg_value(s, a)};
        end
        return w;
    endfunction

    // link edges are found on the second synchroniser stage against its delayed copy
    assign ck_rise = st_r.ck_s2 & ~st_r.ck_s3;
    assign ck_fall = ~st_r.ck_s2 & st_r.ck_s3;
    assign cmd_valid = ~st_r.cs_n_s2 & (st_r.ca_s2[2:0] != CMD_NOP);
    assign mrr_busy = st_r.wait_fall | st_r.lat_run | st_r.burst_on;
    assign apb_setup = PSEL & ~PENABLE & ~st_r.pready;
    assign apb_write = PSEL & PENABLE & st_r.pready & PWRITE;
    assign tsi_wrap = st_r.tsi_cnt == TSI_W'(TSI_CYCLES - 1);
    assign ref_step = st_r.sr_active & (st_r.ref_timer == 10'(REF_STEP_CYC - 1));

    // next state
    always_comb begin
        st_nxt = st_r;
        // two-stage synchronisers on every link and sensor input
        st_nxt.ck_s1 = CK;
        st_nxt.ck_s2 = st_r.ck_s1;
        st_nxt.ck_s3 = st_r.ck_s2;
        st_nxt.cke_s1 = CKE;
        st_nxt.cke_s2 = st_r.cke_s1;
        st_nxt.cs_n_s1 = CS_N;
        st_nxt.cs_n_s2 = st_r.cs_n_s1;
        st_nxt.ca_s1 = CA;
        st_nxt.ca_s2 = st_r.ca_s1;
        st_nxt.temp_s1 = TEMP_CODE;
        st_nxt.temp_s2 = st_r.temp_s1;

        // apb: zero-wait answer in the first access cycle
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (apb_setup) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h00000000;
            if (PADDR == OFS_BANK_MASK) begin
                st_nxt.prdata[7:0] = st_r.bank_mask;
            end else if (PADDR == OFS_SEG_MASK) begin
                st_nxt.prdata[7:0] = st_r.seg_mask;
            end else if (PADDR == OFS_CONFIG) begin
                st_nxt.prdata[3:0] = st_r.rl;
            end else if (PADDR == OFS_STATUS) begin
                st_nxt.prdata[ST_SR] = st_r.sr_active;
                st_nxt.prdata[ST_XSR] = st_r.xsr_cnt != 8'h00;
                st_nxt.prdata[ST_MRR] = mrr_busy;
                st_nxt.prdata[ST_ERR_NOREF] = st_r.err_noref;
                st_nxt.prdata[ST_ERR_XSRCMD] = st_r.err_xsrcmd;
            end else if (PADDR == OFS_TEMP) begin
                st_nxt.prdata[2:0] = st_r.temp_status;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
        // writes land before the link events below, so a same-cycle error set wins
        if (apb_write) begin
            if (PADDR == OFS_BANK_MASK) begin
                st_nxt.bank_mask = PWDATA[7:0];
            end else if (PADDR == OFS_SEG_MASK) begin
                st_nxt.seg_mask = PWDATA[7:0];
            end else if (PADDR == OFS_CONFIG) begin
                // a latency of zero cannot be served, so it is held at one
                st_nxt.rl = (PWDATA[3:0] == 4'h0) ? 4'h1 : PWDATA[3:0];
            end else if (PADDR == OFS_STATUS) begin
                if (PWDATA[ST_ERR_NOREF]) begin
                    st_nxt.err_noref = 1'b0;
                end
                if (PWDATA[ST_ERR_XSRCMD]) begin
                    st_nxt.err_xsrcmd = 1'b0;
                end
            end
        end

        // periodic temperature sampling
        st_nxt.tsi_cnt = st_r.tsi_cnt + TSI_W'(1);
        if (tsi_wrap) begin
            st_nxt.tsi_cnt = '0;
            st_nxt.temp_status = st_r.temp_s2;
        end

        // internal refresh walk over bank and segment while in self refresh
        st_nxt.ref_stb = 1'b0;
        if (st_r.sr_active) begin
            st_nxt.ref_timer = st_r.ref_timer + 10'd1;
        end
        if (ref_step) begin
            st_nxt.ref_timer = 10'd0;
            st_nxt.ref_ptr = st_r.ref_ptr + 6'd1;
            st_nxt.ref_bank = st_r.ref_ptr[5:3];
            st_nxt.ref_seg = st_r.ref_ptr[2:0];
            // a set mask bit blocks the refresh, bank first then segment
            st_nxt.ref_stb = ~st_r.bank_mask[st_r.ref_ptr[5:3]]
                & ~st_r.seg_mask[st_r.ref_ptr[2:0]];
        end

        // burst beats advance on every link edge
        if (st_r.burst_on && (ck_rise || ck_fall)) begin
            if (st_r.beat == 2'd3) begin
                st_nxt.burst_on = 1'b0;
                st_nxt.dq_oe = 1'b0;
                st_nxt.dqs_oe = 1'b0;
                st_nxt.dq_o = '0;
                st_nxt.dqs_t = '0;
                st_nxt.dqs_c = '0;
            end else begin
                st_nxt.beat = st_r.beat + 2'd1;
                st_nxt.dq_o = beat_word(st_r, st_r.addr, st_r.beat + 2'd1);
                st_nxt.dqs_t = ~st_r.dqs_t;
                st_nxt.dqs_c = ~st_r.dqs_c;
            end
        end

        // upper address bits ride the falling edge after the command
        if (ck_fall && st_r.wait_fall) begin
            st_nxt.wait_fall = 1'b0;
            st_nxt.addr = {st_r.ca_s2[1:0], st_r.addr_lo};
        end

        if (ck_rise) begin
            st_nxt.cke_prev = st_r.cke_s2;
            // read latency counted in rising link edges after the command
            if (st_r.lat_run) begin
                if (st_r.lat_cnt == 4'h1) begin
                    st_nxt.lat_run = 1'b0;
                    st_nxt.burst_on = 1'b1;
                    st_nxt.beat = 2'd0;
                    st_nxt.dq_o = beat_word(st_r, st_r.addr, 2'd0);
                    st_nxt.dq_oe = 1'b1;
                    st_nxt.dqs_oe = 1'b1;
                    st_nxt.dqs_t = '1;
                    st_nxt.dqs_c = '0;
                end else begin
                    st_nxt.lat_cnt = st_r.lat_cnt - 4'h1;
                end
            end
            if (st_r.sr_active) begin
                if (st_r.cke_s2) begin
                    // exit: fresh sensor reading and a new exit window
                    st_nxt.sr_active = 1'b0;
                    st_nxt.xsr_cnt = 8'(XSR_CYCLES);
                    st_nxt.ref_ok = 1'b0;
                    st_nxt.pb_cnt = 4'h0;
                    st_nxt.temp_status = st_r.temp_s2;
                    st_nxt.tsi_cnt = '0;
                end
            end else if (st_r.xsr_cnt != 8'h00) begin
                st_nxt.xsr_cnt = st_r.xsr_cnt - 8'h01;
                if (cmd_valid) begin
                    st_nxt.err_xsrcmd = 1'b1;
                end
            end else if (st_r.cke_prev && !st_r.cs_n_s2 && st_r.ca_s2[2:0] == CMD_REF) begin
                if (!st_r.cke_s2) begin
                    // self refresh entry
                    st_nxt.sr_active = 1'b1;
                    st_nxt.ref_timer = 10'd0;
                    if (!st_r.ref_ok) begin
                        st_nxt.err_noref = 1'b1;
                    end
                end else if (st_r.ca_s2[3]) begin
                    st_nxt.ref_ok = 1'b1;
                end else begin
                    st_nxt.pb_cnt = st_r.pb_cnt + 4'h1;
                    if (st_r.pb_cnt == 4'h7) begin
                        st_nxt.ref_ok = 1'b1;
                    end
                end
            end else if (st_r.cke_s2 && !st_r.cs_n_s2 && st_r.ca_s2[3:0] == CMD_MRR
                         && !mrr_busy) begin
                st_nxt.addr_lo = st_r.ca_s2[9:4];
                st_nxt.wait_fall = 1'b1;
                st_nxt.lat_run = 1'b1;
                st_nxt.lat_cnt = st_r.rl;
            end
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_r <= '0;
            st_r.rl <= RL_RST;
            st_r.bank_mask <= MASK_RST;
            st_r.seg_mask <= MASK_RST;
            st_r.ref_ok <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;
    assign DQ_O = st_r.dq_o;
    assign DQ_OE = st_r.dq_oe;
    assign DQS_T_O = st_r.dqs_t;
    assign DQS_C_O = st_r.dqs_c;
    assign DQS_OE = st_r.dqs_oe;
    assign ARRAY_REF_STB = st_r.ref_stb;
    assign ARRAY_REF_BANK = st_r.ref_bank;
    assign ARRAY_REF_SEG = st_r.ref_seg;

    // checks
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_mrr_cmd;
        ck_rise && st_r.cke_s2 && !st_r.cs_n_s2 && st_r.ca_s2[3:0] == CMD_MRR && !mrr_busy
            && st_r.xsr_cnt == 8'h00 && !st_r.sr_active
            && !(st_r.cke_prev && st_r.ca_s2[2:0] == CMD_REF);
    endsequence
    sequence s_addr_fall;
        ck_fall && st_r.wait_fall;
    endsequence

    property p_bank_masked;
        ARRAY_REF_STB |-> !st_r.bank_mask[ARRAY_REF_BANK] && $past(st_r.sr_active);
    endproperty
    a_bank_masked: assert property (p_bank_masked) else $error("refresh of masked bank");

    property p_unmasked_refreshed;
        ref_step && !st_r.bank_mask[st_r.ref_ptr[5:3]] && !st_r.seg_mask[st_r.ref_ptr[2:0]]
            |=> ARRAY_REF_STB && ARRAY_REF_SEG == $past(st_r.ref_ptr[2:0]);
    endproperty
    a_unmasked_refreshed: assert property (p_unmasked_refreshed) else $error("refresh lost");

    property p_seg_masked;
        ARRAY_REF_STB |-> !st_r.seg_mask[ARRAY_REF_SEG];
    endproperty
    a_seg_masked: assert property (p_seg_masked) else $error("refresh of masked segment");

    property p_mask_one_blocks;
        ref_step && (st_r.bank_mask[st_r.ref_ptr[5:3]] || st_r.seg_mask[st_r.ref_ptr[2:0]])
            |=> !ARRAY_REF_STB;
    endproperty
    a_mask_one_blocks: assert property (p_mask_one_blocks) else $error("mask one ignored");

    property p_bit_order;
        ref_step |=> ARRAY_REF_BANK == $past(st_r.ref_ptr[5:3]);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("bank index mismatch");

    property p_mrr_decode;
        s_mrr_cmd |=> st_r.lat_run && st_r.wait_fall && st_r.lat_cnt == $past(st_r.rl);
    endproperty
    a_mrr_decode: assert property (p_mrr_decode) else $error("register read not decoded");

    property p_addr_form;
        s_addr_fall |=> st_r.addr == {$past(st_r.ca_s2[1:0]), $past(st_r.addr_lo)};
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("address formed wrongly");

    property p_first_beat;
        $rose(st_r.burst_on) && st_r.addr != MA_CAL_A && st_r.addr != MA_CAL_B
            |-> DQ_O[7:0] == reg_value(st_r, st_r.addr) && DQ_OE;
    endproperty
    a_first_beat: assert property (p_first_beat) else $error("first beat wrong");

    property p_strobe_toggle;
        st_r.burst_on && (ck_rise || ck_fall) && st_r.beat != 2'd3
            |=> DQS_OE && DQS_T_O == ~$past(DQS_T_O) && DQS_C_O == ~DQS_T_O;
    endproperty
    a_strobe_toggle: assert property (p_strobe_toggle) else $error("strobe did not toggle");

    property p_reserved;
        $rose(st_r.burst_on) && st_r.addr[7:6] != 2'b00 |-> DQ_O == '0 && DQS_OE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read filler wrong");

    property p_tsi_bound;
        st_r.tsi_cnt < TSI_W'(TSI_CYCLES)
            and (tsi_wrap |=> st_r.temp_status == $past(st_r.temp_s2));
    endproperty
    a_tsi_bound: assert property (p_tsi_bound) else $error("temperature status stale");

    property p_cal_lane;
        st_r.burst_on && st_r.addr == MA_CAL_B |-> DQ_O[0] == CAL_B_PAT[st_r.beat]
            && DQ_O[8] == DQ_O[0] && DQ_O[16] == DQ_O[0] && DQ_O[24] == DQ_O[0];
    endproperty
    a_cal_lane: assert property (p_cal_lane) else $error("calibration lane bit wrong");

    property p_cal_copy;
        st_r.burst_on && (st_r.addr == MA_CAL_A || st_r.addr == MA_CAL_B)
            |-> DQ_O == {DQ_W{DQ_O[0]}};
    endproperty
    a_cal_copy: assert property (p_cal_copy) else $error("calibration bits differ");

    property p_cal_a;
        st_r.burst_on && st_r.addr == MA_CAL_A |-> DQ_O[0] == CAL_A_PAT[st_r.beat];
    endproperty
    a_cal_a: assert property (p_cal_a) else $error("pattern A wrong");

endmodule

// ### tb/mrp_ctrl_model.sv
// memory controller model: link clock, clock enable and command/address bus
`timescale 1ns/1ns
module mrp_ctrl_model
    import mrp_pkg::*;
(
    // link clock and command bus towards the device
    output logic CK,
    output logic CKE,
    output logic CS_N,
    output logic [CA_W-1:0] CA
);
    // clock runs free; the 1 ns offset keeps its edges off the system clock edges
    initial begin
        CK = 1'b0;
        CKE = 1'b1;
        CS_N = 1'b1;
        CA = 10'h3ff;
        #1;
        forever #32 CK = ~CK;
    end
    // one slot: each half is driven a quarter period after an edge, so it stands
    // across the next edge; changing on the edge itself would leave no hold time
    task automatic cmd(input logic cs_n, input logic cke, input logic [9:0] car,
                       input logic [9:0] caf);
        @(negedge CK);
        #16;
        CS_N <= cs_n;
        CKE <= cke;
        CA <= car;
        @(posedge CK);
        #16;
        CA <= caf;
    endtask
    // idle slots; deselect acts as a no-operation
    task automatic nops(input int n, input logic cke);
        repeat (n) cmd(1'b1, cke, 10'h3ff, 10'h3ff);
    endtask
    // no data reads or writes are issued, so their spacing never arises
    task automatic register_read_command(input logic [7:0] ma);
        cmd(1'b0, 1'b1, {ma[5:0], 4'h8}, {8'ha5, ma[7:6]});
        nops(2, 1'b1);
    endtask
    // all-bank refresh between self refresh periods
    task automatic ref_all();
        cmd(1'b0, 1'b1, 10'h00c, 10'h3ff);
        nops(1, 1'b1);
    endtask
    // entry with every bank idle: this model never opens a row
    task automatic sr_enter();
        nops(1, 1'b1);
        cmd(1'b0, 1'b0, 10'h004, 10'h3ff);
        nops(1, 1'b0);
    endtask
    // stable clock before clock enable rises, then no-operations through the exit delay
    task automatic sr_exit(input int xsr);
        nops(2, 1'b0);
        nops(xsr + 2, 1'b1);
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench: apb registers, register reads on the link, self refresh
`timescale 1ns/1ns
module testbench;
    import mrp_pkg::*;
    localparam int TSI_T = 8000;
    localparam logic [7:0] BM = 8'h82;
    localparam logic [7:0] SM = 8'h84;
    localparam logic [31:0] F1 = 32'hffffffff;
    localparam logic [31:0] Z = 32'h0;
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CK, CKE, CS_N;
    logic DQ_OE, DQS_OE, ARRAY_REF_STB, err, sr_watch;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [CA_W-1:0] CA;
    logic [DQ_W-1:0] DQ_O;
    logic [LANES-1:0] DQS_T_O, DQS_C_O;
    logic [2:0] TEMP_CODE, ARRAY_REF_BANK, ARRAY_REF_SEG;
    int bad_count, samples_checked, ref_seen, lat3, lat5;
`define CHK(exp, got, what) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
    mrp_core #(.TSI_CYCLES(TSI_T)) dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .CK(CK), .CKE(CKE), .CS_N(CS_N), .CA(CA),
        .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQS_T_O(DQS_T_O), .DQS_C_O(DQS_C_O), .DQS_OE(DQS_OE),
        .TEMP_CODE(TEMP_CODE), .ARRAY_REF_STB(ARRAY_REF_STB), .ARRAY_REF_BANK(ARRAY_REF_BANK),
        .ARRAY_REF_SEG(ARRAY_REF_SEG));
    mrp_ctrl_model ctl_u (.CK(CK), .CKE(CKE), .CS_N(CS_N), .CA(CA));
    // system clock, 4 ns
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // one apb transfer; waits for pready under a bound rather than assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 64);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(exp, rd, "register value")
        `CHK(1'b0, err, "slave error")
    endtask
    // register read on the link; latency counted in system clocks from the command rise
    task automatic mrr_chk(input logic [7:0] ma, input logic [31:0] b[4], output int lat);
        int n;
        fork
            ctl_u.register_read_command(ma);
            begin
                @(negedge CK);
                @(posedge CK);
                n = 0;
                while (DQ_OE !== 1'b1 && n < 400) begin
                    @(posedge CLK);
                    n++;
                end
                lat = n;
                if (n >= 400) begin
                    bad_count++;
                    give_verdict();
                end
                // sample each beat well inside its half link period
                for (int i = 0; i < 4; i++) begin
                    repeat (i == 0 ? 3 : 8) @(posedge CLK);
                    `CHK(b[i], DQ_O, "read beat")
                    `CHK(i[0] ? 4'h0 : 4'hf, DQS_T_O, "true strobe")
                    `CHK(i[0] ? 4'hf : 4'h0, DQS_C_O, "complement strobe")
                    `CHK(1'b1, DQS_OE, "strobe enable")
                end
                repeat (8) @(posedge CLK);
                `CHK(1'b0, DQ_OE | DQS_OE, "enables after burst")
            end
        join
    endtask
    // every refresh strobe seen in self refresh must hit an unmasked bank and segment
    always @(posedge CLK) begin
        if (sr_watch && ARRAY_REF_STB === 1'b1) begin
            ref_seen++;
            `CHK(1'b0, BM[ARRAY_REF_BANK] | SM[ARRAY_REF_SEG], "masked refresh")
        end
    end
    initial begin
        {PSEL, PENABLE, PWRITE, sr_watch} = 4'h0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        TEMP_CODE = 3'h3;
        RST_N = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        ref_seen = 0;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        // reset values and an unmapped place
        chk_reg(OFS_BANK_MASK, Z);
        chk_reg(OFS_SEG_MASK, Z);
        chk_reg(OFS_CONFIG, 32'h3);
        chk_reg(OFS_STATUS, Z);
        apb(1'b0, 12'h020, Z);
        `CHK(1'b1, err, "unmapped error")
        done("reset");
        // masks and fixed patterns read back over the link
        apb(1'b1, OFS_BANK_MASK, {24'h0, BM});
        apb(1'b1, OFS_SEG_MASK, {24'h0, SM});
        mrr_chk(MA_BANK_MASK, '{{24'h0, BM}, Z, Z, Z}, lat3);
        mrr_chk(MA_SEG_MASK, '{{24'h0, SM}, Z, Z, Z}, lat3);
        mrr_chk(8'h90, '{Z, Z, Z, Z}, lat3);
        mrr_chk(MA_CAL_A, '{F1, Z, F1, Z}, lat3);
        mrr_chk(MA_CAL_B, '{Z, Z, F1, F1}, lat3);
        done("register read");
        // periodic temperature update, then a longer read latency
        repeat (TSI_T + 40) @(posedge CLK);
        chk_reg(OFS_TEMP, 32'h3);
        apb(1'b1, OFS_CONFIG, 32'h5);
        mrr_chk(MA_TEMP, '{32'h3, Z, Z, Z}, lat5);
        `CHK(32, lat5 - lat3, "latency step")
        apb(1'b1, OFS_CONFIG, 32'h3);
        done("temperature");
        // one full pass of the refresh pointer: 6 banks times 6 segments unmasked
        ctl_u.sr_enter();
        sr_watch = 1'b1;
        repeat (64 * 975) @(posedge CLK);
        #1;
        sr_watch = 1'b0;
        `CHK(36, ref_seen, "refresh count")
        chk_reg(OFS_STATUS, 32'h1);
        @(posedge CLK);
        TEMP_CODE <= 3'h6;
        // exit with a read placed inside the exit delay on purpose
        ctl_u.nops(2, 1'b0);
        ctl_u.nops(2, 1'b1);
        ctl_u.register_read_command(MA_TEMP);
        ctl_u.nops(8, 1'b1);
        chk_reg(OFS_STATUS, 32'h10);
        chk_reg(OFS_TEMP, 32'h6);
        apb(1'b1, OFS_STATUS, 32'h10);
        chk_reg(OFS_STATUS, Z);
        done("exit window");
        // re-entry without a refresh, then with one
        ctl_u.sr_enter();
        chk_reg(OFS_STATUS, 32'h9);
        ctl_u.sr_exit(XSR_LINK_CYC);
        apb(1'b1, OFS_STATUS, 32'h8);
        ctl_u.ref_all();
        ctl_u.sr_enter();
        chk_reg(OFS_STATUS, 32'h1);
        ctl_u.sr_exit(XSR_LINK_CYC);
        // seven per-bank refreshes fall short, eight complete the cycle
        repeat (7) ctl_u.cmd(1'b0, 1'b1, 10'h004, 10'h3ff);
        ctl_u.sr_enter();
        chk_reg(OFS_STATUS, 32'h9);
        ctl_u.sr_exit(XSR_LINK_CYC);
        apb(1'b1, OFS_STATUS, 32'h8);
        repeat (8) ctl_u.cmd(1'b0, 1'b1, 10'h004, 10'h3ff);
        ctl_u.sr_enter();
        chk_reg(OFS_STATUS, 32'h1);
        ctl_u.sr_exit(XSR_LINK_CYC);
        done("refresh before re-entry");
        give_verdict();
    end
endmodule
